// *** rtl/fsc_decoder.sv ***
// Feature-selection command decoder and drive settings store
`default_nettype none
module fsc_decoder (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_code_i,
  input  wire logic [7:0] features_i,
  input  wire logic [7:0] sector_count_i,
  input  wire logic       soft_reset_i,
  input  wire logic       flush_done_i,
  input  wire logic       data_reg_access_i,
  output var  logic       busy_o,
  output var  logic       done_o,
  output var  logic       abort_o,
  output var  logic [7:0] cyl_low_o,
  output var  logic [7:0] cyl_high_o,
  output var  logic       cyl_load_o,
  output var  logic       flush_start_o,
  output var  logic       byte_mode_o,
  output var  logic       sixteen_bit_io_indicator_o,
  output var  logic       write_cache_o,
  output var  logic       pio_mode_valid_o,
  output var  logic [2:0] pio_mode_o,
  output var  logic       iordy_en_o,
  output var  logic       dma_is_udma_o,
  output var  logic [2:0] dma_mode_o,
  output var  logic       apm_en_o,
  output var  logic [7:0] apm_level_o,
  output var  logic       apm_standby_ok_o,
  output var  logic       ext_power_o,
  output var  logic       pl1_en_o,
  output var  logic       look_ahead_o,
  output var  logic       ecc4_o,
  output var  logic       por_reload_o,
  output var  logic [7:0] cur_limit_o
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clamp host current request into supported range
  function automatic logic [7:0] clamp_cur(input logic [7:0] v);
    if (v < fsc_pkg::CUR_MIN) begin
      clamp_cur = fsc_pkg::CUR_MIN;
    end else if (v > fsc_pkg::CUR_MAX) begin
      clamp_cur = fsc_pkg::CUR_MAX;
    end else begin
      clamp_cur = v;
    end
  endfunction : clamp_cur

  // Ready handshake needed for the given PIO mode
  function automatic logic rdy_need(input logic [2:0] m);
    rdy_need = (m >= fsc_pkg::PIO_RDY_MIN);
  endfunction : rdy_need

  //////////////////////////////////////////////////////////////////////////
  // State

  fsc_pkg::fsc_state_t state;
  fsc_pkg::fsc_state_t next_state;
  logic [7:0] feat;
  logic [7:0] next_feat;
  logic [7:0] parm;
  logic [7:0] next_parm;
  logic [15:0] fcnt;
  logic [15:0] next_fcnt;
  logic next_busy;
  logic next_done;
  logic next_abort;
  logic [7:0] next_cyl_low;
  logic [7:0] next_cyl_high;
  logic next_cyl_load;
  logic next_flush_start;
  logic next_byte_mode;
  logic next_write_cache;
  logic [2:0] next_pio_mode;
  logic next_iordy_en;
  logic next_dma_is_udma;
  logic [2:0] next_dma_mode;
  logic next_apm_en;
  logic [7:0] next_apm_level;
  logic next_ext_power;
  logic next_pl1_en;
  logic next_look_ahead;
  logic next_ecc4;
  logic next_por_reload;
  logic [7:0] next_cur_limit;
  logic next_sixteen;
  logic [4:0] xtype;
  logic [2:0] xmode;

  assign xtype = parm[7:3];
  assign xmode = parm[2:0];

  //////////////////////////////////////////////////////////////////////////
  // Next-value logic

  always_comb begin
    next_state       = state;
    next_feat        = feat;
    next_parm        = parm;
    next_fcnt        = fcnt;
    next_busy        = busy_o;
    next_done        = 1'b0;
    next_abort       = abort_o;
    next_cyl_low     = cyl_low_o;
    next_cyl_high    = cyl_high_o;
    next_cyl_load    = 1'b0;
    next_flush_start = 1'b0;
    next_byte_mode   = byte_mode_o;
    next_write_cache = write_cache_o;
    next_pio_mode    = pio_mode_o;
    next_iordy_en    = iordy_en_o;
    next_dma_is_udma = dma_is_udma_o;
    next_dma_mode    = dma_mode_o;
    next_apm_en      = apm_en_o;
    next_apm_level   = apm_level_o;
    next_ext_power   = ext_power_o;
    next_pl1_en      = pl1_en_o;
    next_look_ahead  = look_ahead_o;
    next_ecc4        = ecc4_o;
    next_por_reload  = por_reload_o;
    next_cur_limit   = cur_limit_o;
    // Soft reset while idle reloads defaults unless disabled
    if (soft_reset_i && por_reload_o && state == fsc_pkg::FSC_IDLE) begin
      next_byte_mode   = fsc_pkg::RST_BYTE;
      next_write_cache = fsc_pkg::RST_WC;
      next_pio_mode    = fsc_pkg::RST_PIO;
      next_iordy_en    = 1'b1;
      next_dma_is_udma = 1'b0;
      next_dma_mode    = 3'h0;
      next_apm_en      = 1'b0;
      next_apm_level   = fsc_pkg::APM_DEF;
      next_ext_power   = 1'b0;
      next_pl1_en      = 1'b0;
      next_look_ahead  = fsc_pkg::RST_RLA;
      next_ecc4        = fsc_pkg::RST_ECC4;
      next_cur_limit   = fsc_pkg::CUR_MAX;
    end
    case (state)
      fsc_pkg::FSC_IDLE: begin
        if (cmd_valid_i && cmd_code_i == fsc_pkg::CMD_SET_FEATURES) begin
          next_feat  = features_i;
          next_parm  = sector_count_i;
          next_busy  = 1'b1;
          next_abort = 1'b0;
          next_state = fsc_pkg::FSC_EXEC;
        end
      end
      fsc_pkg::FSC_EXEC: begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = fsc_pkg::FSC_IDLE;
        case (feat)
          fsc_pkg::SC_BYTE_ON:  next_byte_mode = 1'b1;
          fsc_pkg::SC_BYTE_OFF: next_byte_mode = 1'b0;
          fsc_pkg::SC_WC_ON:    next_write_cache = 1'b1;
          fsc_pkg::SC_WC_OFF: begin
            next_write_cache = 1'b0;
            next_flush_start = 1'b1;
            next_fcnt        = 16'(fsc_pkg::FLUSH_CYCLES);
            next_busy        = 1'b1;
            next_done        = 1'b0;
            next_state       = fsc_pkg::FSC_FLUSH;
          end
          fsc_pkg::SC_XFER: begin
            // Only listed types and supported mode numbers pass
            if (xtype == fsc_pkg::XT_DEFAULT && xmode == fsc_pkg::XM_DEF) begin
              next_pio_mode = fsc_pkg::RST_PIO;
              next_iordy_en = 1'b1;
            end else if (xtype == fsc_pkg::XT_DEFAULT && xmode == fsc_pkg::XM_NORDY) begin
              next_pio_mode = fsc_pkg::RST_PIO;
              next_iordy_en = 1'b0;
            end else if (xtype == fsc_pkg::XT_PIO && xmode <= fsc_pkg::PIO_MAX) begin
              next_pio_mode = xmode;
              next_iordy_en = rdy_need(xmode) ? 1'b1 : iordy_en_o;
            end else if (xtype == fsc_pkg::XT_MDMA && xmode <= fsc_pkg::MDMA_MAX) begin
              next_dma_is_udma = 1'b0;
              next_dma_mode    = xmode;
            end else if (xtype == fsc_pkg::XT_UDMA && xmode <= fsc_pkg::UDMA_MAX) begin
              next_dma_is_udma = 1'b1;
              next_dma_mode    = xmode;
            end else begin
              next_abort = 1'b1;
            end
          end
          fsc_pkg::SC_APM_ON: begin
            if (parm == fsc_pkg::APM_RES_LO || parm == fsc_pkg::APM_RES_HI) begin
              next_abort = 1'b1;
            end else begin
              next_apm_en    = 1'b1;
              next_apm_level = parm;
            end
          end
          fsc_pkg::SC_APM_OFF:  next_apm_en = 1'b0;
          fsc_pkg::SC_EXTP_ON:  next_ext_power = 1'b1;
          fsc_pkg::SC_EXTP_OFF: next_ext_power = 1'b0;
          fsc_pkg::SC_PL1_ON:   next_pl1_en = 1'b1;
          fsc_pkg::SC_PL1_OFF:  next_pl1_en = 1'b0;
          fsc_pkg::SC_RLA_OFF:  next_look_ahead = 1'b0;
          fsc_pkg::SC_RLA_ON:   next_look_ahead = 1'b1;
          fsc_pkg::SC_POR_OFF:  next_por_reload = 1'b0;
          fsc_pkg::SC_POR_ON:   next_por_reload = 1'b1;
          fsc_pkg::SC_NOP_A, fsc_pkg::SC_NOP_B, fsc_pkg::SC_NOP_C: begin
            next_abort = 1'b0;
          end
          fsc_pkg::SC_CURLIM: begin
            next_cur_limit = clamp_cur(parm);
            next_cyl_low   = fsc_pkg::CUR_MIN;
            next_cyl_high  = fsc_pkg::CUR_MAX;
            next_cyl_load  = 1'b1;
          end
          fsc_pkg::SC_ECC4:     next_ecc4 = 1'b1;
          default:              next_abort = 1'b1;
        endcase
      end
      fsc_pkg::FSC_FLUSH: begin
        // Completion waits for flush and minimum time
        if (fcnt != 16'h0000) begin
          next_fcnt = fcnt - 16'h0001;
        end
        if (flush_done_i && fcnt == 16'h0000) begin
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_state = fsc_pkg::FSC_IDLE;
        end
      end
      default: next_state = fsc_pkg::FSC_IDLE;
    endcase
    // Byte mode keeps the 16-bit indicator low
    next_sixteen = data_reg_access_i && !next_byte_mode;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state         <= fsc_pkg::FSC_IDLE;
      feat          <= 8'h00;
      parm          <= 8'h00;
      fcnt          <= 16'h0000;
      busy_o        <= 1'b0;
      done_o        <= 1'b0;
      abort_o       <= 1'b0;
      cyl_low_o     <= 8'h00;
      cyl_high_o    <= 8'h00;
      cyl_load_o    <= 1'b0;
      flush_start_o <= 1'b0;
      byte_mode_o   <= fsc_pkg::RST_BYTE;
      write_cache_o <= fsc_pkg::RST_WC;
      pio_mode_o    <= fsc_pkg::RST_PIO;
      iordy_en_o    <= 1'b1;
      dma_is_udma_o <= 1'b0;
      dma_mode_o    <= 3'h0;
      apm_en_o      <= 1'b0;
      apm_level_o   <= fsc_pkg::APM_DEF;
      ext_power_o   <= 1'b0;
      pl1_en_o      <= 1'b0;
      look_ahead_o  <= fsc_pkg::RST_RLA;
      ecc4_o        <= fsc_pkg::RST_ECC4;
      por_reload_o  <= fsc_pkg::RST_POR;
      cur_limit_o   <= fsc_pkg::CUR_MAX;
      sixteen_bit_io_indicator_o <= 1'b0;
      apm_standby_ok_o <= 1'b0;
      pio_mode_valid_o <= 1'b1;
    end else begin
      state         <= next_state;
      feat          <= next_feat;
      parm          <= next_parm;
      fcnt          <= next_fcnt;
      busy_o        <= next_busy;
      done_o        <= next_done;
      abort_o       <= next_abort;
      cyl_low_o     <= next_cyl_low;
      cyl_high_o    <= next_cyl_high;
      cyl_load_o    <= next_cyl_load;
      flush_start_o <= next_flush_start;
      byte_mode_o   <= next_byte_mode;
      write_cache_o <= next_write_cache;
      pio_mode_o    <= next_pio_mode;
      iordy_en_o    <= next_iordy_en;
      dma_is_udma_o <= next_dma_is_udma;
      dma_mode_o    <= next_dma_mode;
      apm_en_o      <= next_apm_en;
      apm_level_o   <= next_apm_level;
      ext_power_o   <= next_ext_power;
      pl1_en_o      <= next_pl1_en;
      look_ahead_o  <= next_look_ahead;
      ecc4_o        <= next_ecc4;
      por_reload_o  <= next_por_reload;
      cur_limit_o   <= next_cur_limit;
      sixteen_bit_io_indicator_o <= next_sixteen;
      apm_standby_ok_o <= next_apm_en && (next_apm_level < fsc_pkg::APM_NOSTBY);
      pio_mode_valid_o <= 1'b1;
    end
  end

endmodule : fsc_decoder
`default_nettype wire

// *** rtl/fsc_pkg.sv ***
// Constants and types for the feature-selection command decoder
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Unsupported or invalid subcommand or parameter ends command with abort error.
// - 01h enables, 81h disables byte-wide transfers; 16-bit indicator stays low.
// - 02h enables, 82h disables write cache; disable flushes before completion.
// - 03h takes transfer mode from sector count: type high five, mode low three.
// - Type 00001b PIO, 00100b multiword DMA, 01000b Ultra DMA, others reserved.
// - Type zero, mode 000b default PIO; 001b default PIO and ready off.
// - Exactly one PIO mode, and exactly one DMA mode, always selected.
// - Ultra DMA selection cancels multiword DMA and the reverse.
// - Ready handshake is supported whenever PIO mode is 3 or above.
// - Every mode number up to the highest supported is accepted.
// - 05h takes power level 01h..FEh from sector count; enables advanced power management.
// - 80h min no standby, 81h-FDh no standby, 02h-7Fh standby, FFh/00h reserved.
// - 85h turns advanced power management off.
// - 0Ah/8Ah enable/disable power level 1; default is disabled.
// - 55h disables, AAh enables look-ahead; 55h and BBh states are defaults.
// - BBh sets four ECC bytes per sector on long read and write.
// - 9Ah sector count is quarter of host current limit in mA.
// - After 9Ah, lowest value to cylinder low, highest to cylinder high.
// - Out-of-range current limits clamp; power-on default is highest performance.
// - 66h stops, CCh restores default reload on soft reset; default reloads.
// - 69h, 96h, 97h accepted with no effect; 09h/89h extended power on/off.
// - Aborted subcommand sets abort error and leaves settings unchanged.
`default_nettype none
package fsc_pkg;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] SC_BYTE_ON       = 8'h01;
  localparam logic [7:0] SC_BYTE_OFF      = 8'h81;
  localparam logic [7:0] SC_WC_ON         = 8'h02;
  localparam logic [7:0] SC_WC_OFF        = 8'h82;
  localparam logic [7:0] SC_XFER          = 8'h03;
  localparam logic [7:0] SC_APM_ON        = 8'h05;
  localparam logic [7:0] SC_APM_OFF       = 8'h85;
  localparam logic [7:0] SC_EXTP_ON       = 8'h09;
  localparam logic [7:0] SC_EXTP_OFF      = 8'h89;
  localparam logic [7:0] SC_PL1_ON        = 8'h0A;
  localparam logic [7:0] SC_PL1_OFF       = 8'h8A;
  localparam logic [7:0] SC_RLA_OFF       = 8'h55;
  localparam logic [7:0] SC_RLA_ON        = 8'hAA;
  localparam logic [7:0] SC_POR_OFF       = 8'h66;
  localparam logic [7:0] SC_POR_ON        = 8'hCC;
  localparam logic [7:0] SC_NOP_A         = 8'h69;
  localparam logic [7:0] SC_NOP_B         = 8'h96;
  localparam logic [7:0] SC_NOP_C         = 8'h97;
  localparam logic [7:0] SC_CURLIM        = 8'h9A;
  localparam logic [7:0] SC_ECC4          = 8'hBB;
  // Transfer type field values
  localparam logic [4:0] XT_DEFAULT = 5'h00;
  localparam logic [4:0] XT_PIO     = 5'h01;
  localparam logic [4:0] XT_MDMA    = 5'h04;
  localparam logic [4:0] XT_UDMA    = 5'h08;
  localparam logic [2:0] XM_DEF     = 3'h0;
  localparam logic [2:0] XM_NORDY   = 3'h1;
  // Highest supported modes; lowest PIO mode needing ready
  localparam logic [2:0] PIO_MAX    = 3'h4;
  localparam logic [2:0] MDMA_MAX   = 3'h2;
  localparam logic [2:0] UDMA_MAX   = 3'h4;
  localparam logic [2:0] PIO_RDY_MIN = 3'h3;
  // Power level limits
  localparam logic [7:0] APM_RES_LO = 8'h00;
  localparam logic [7:0] APM_RES_HI = 8'hFF;
  localparam logic [7:0] APM_DEF    = 8'hFE;
  localparam logic [7:0] APM_NOSTBY = 8'h80;
  // Current limit range, 4 mA units
  localparam logic [7:0] CUR_MIN    = 8'h0A;
  localparam logic [7:0] CUR_MAX    = 8'h32;
  // Flush time
  localparam int FLUSH_NS     = 1000;
  localparam int CLK_NS       = 8;
  localparam int FLUSH_CYCLES = (FLUSH_NS + CLK_NS - 1) / CLK_NS;
  // Reset values of settings
  localparam logic       RST_BYTE  = 1'b0;
  localparam logic       RST_WC    = 1'b1;
  localparam logic [2:0] RST_PIO   = 3'h0;
  localparam logic       RST_RLA   = 1'b0;  // Look-ahead off, as after 55h
  localparam logic       RST_ECC4  = 1'b1;
  localparam logic       RST_POR   = 1'b1;
  typedef enum logic [1:0] {
    FSC_IDLE  = 2'b00,
    FSC_EXEC  = 2'b01,
    FSC_FLUSH = 2'b11
  } fsc_state_t;
endpackage : fsc_pkg
`default_nettype wire

// *** test/fsc_decoder_chk.sv ***
// Assertion checker for the feature-selection command decoder
`default_nettype none
module fsc_decoder_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] features_i,
  input wire logic       flush_done_i,
  input wire logic       data_reg_access_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic       abort_o,
  input wire logic [7:0] cyl_low_o,
  input wire logic [7:0] cyl_high_o,
  input wire logic       cyl_load_o,
  input wire logic       flush_start_o,
  input wire logic       byte_mode_o,
  input wire logic       sixteen_bit_io_indicator_o,
  input wire logic       write_cache_o,
  input wire logic       pio_mode_valid_o,
  input wire logic [2:0] pio_mode_o,
  input wire logic       iordy_en_o,
  input wire logic       dma_is_udma_o,
  input wire logic [2:0] dma_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       take;
  logic       fl_pend, next_fl_pend;
  logic [7:0] fl_cnt, next_fl_cnt;
  assign take = cmd_valid_i && !busy_o && cmd_code_i == fsc_pkg::CMD_SET_FEATURES;
  // Track an open cache flush and its length
  always_comb begin
    next_fl_pend = (fl_pend || flush_start_o) && !done_o;
    next_fl_cnt  = flush_start_o ? 8'h00 : fl_cnt + {7'h00, fl_pend && fl_cnt != 8'hFF};
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fl_pend <= 1'b0;
      fl_cnt  <= 8'h00;
    end else begin
      fl_pend <= next_fl_pend;
      fl_cnt  <= next_fl_cnt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_take_busy: assert property (take |=> busy_o)
    else $error("busy not raised after command");
  chk_quick_done: assert property (take && features_i != fsc_pkg::SC_WC_OFF |=>
    busy_o ##1 (done_o && !busy_o)) else $error("command not completed in two cycles");
  chk_done_edge: assert property (done_o |-> !busy_o && $past(busy_o))
    else $error("done without busy falling");
  chk_flush_start: assert property (take && features_i == fsc_pkg::SC_WC_OFF |->
    ##[1:2] flush_start_o) else $error("flush not started");
  chk_flush_wait: assert property (done_o && fl_pend |->
    fl_cnt >= fsc_pkg::FLUSH_CYCLES && $past(flush_done_i)) else $error("flush cut short");
  chk_cyl_range: assert property (cyl_load_o |-> done_o && !abort_o &&
    cyl_low_o == fsc_pkg::CUR_MIN && cyl_high_o == fsc_pkg::CUR_MAX)
    else $error("current range wrong");
  chk_ready_pio: assert property (pio_mode_o >= fsc_pkg::PIO_RDY_MIN |-> iordy_en_o)
    else $error("ready handshake off in fast mode");
  chk_one_mode: assert property (pio_mode_valid_o && pio_mode_o <= fsc_pkg::PIO_MAX &&
    dma_mode_o <= (dma_is_udma_o ? fsc_pkg::UDMA_MAX : fsc_pkg::MDMA_MAX))
    else $error("mode selection invalid");
  chk_sixteen_narrow: assert property (sixteen_bit_io_indicator_o |->
    $past(data_reg_access_i) && !byte_mode_o) else $error("wide indicator wrong");
  chk_abort_hold: assert property (done_o && abort_o |->
    byte_mode_o == $past(byte_mode_o, 2) && write_cache_o == $past(write_cache_o, 2) &&
    pio_mode_o == $past(pio_mode_o, 2) && dma_mode_o == $past(dma_mode_o, 2))
    else $error("settings changed on abort");
endmodule : fsc_decoder_chk
bind fsc_decoder fsc_decoder_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .features_i(features_i),
  .flush_done_i(flush_done_i), .data_reg_access_i(data_reg_access_i), .busy_o(busy_o),
  .done_o(done_o), .abort_o(abort_o), .cyl_low_o(cyl_low_o), .cyl_high_o(cyl_high_o),
  .cyl_load_o(cyl_load_o), .flush_start_o(flush_start_o), .byte_mode_o(byte_mode_o),
  .sixteen_bit_io_indicator_o(sixteen_bit_io_indicator_o), .write_cache_o(write_cache_o),
  .pio_mode_valid_o(pio_mode_valid_o), .pio_mode_o(pio_mode_o), .iordy_en_o(iordy_en_o),
  .dma_is_udma_o(dma_is_udma_o), .dma_mode_o(dma_mode_o));
`default_nettype wire

// *** test/fsc_host_model.sv ***
// Host-side model: issues commands and completes cache flushes
`default_nettype none
module fsc_host_model (
  input  wire logic       clk_i,
  input  wire logic       busy_i,
  input  wire logic       done_i,
  input  wire logic       flush_start_i,
  output var  logic       cmd_valid_o,
  output var  logic [7:0] cmd_code_o,
  output var  logic [7:0] features_o,
  output var  logic [7:0] sector_count_o,
  output var  logic       flush_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       slow     = 1'b0;
  logic       pend     = 1'b0;
  logic [7:0] wait_cnt = 8'h00;
  initial begin
    {cmd_valid_o, cmd_code_o, features_o, sector_count_o, flush_done_o} = '0;
  end
  // Flush completion, prompt or after a long stall
  always @(negedge clk_i) begin
    if (flush_start_i) begin
      pend = 1'b1;
      wait_cnt = slow ? 8'hC8 : 8'h02;
    end else if (wait_cnt != 8'h00) begin
      wait_cnt = wait_cnt - 8'h01;
    end
    if (done_i) begin
      pend = 1'b0;
    end
    flush_done_o = pend && wait_cnt == 8'h00;
  end
  // One command: wait for idle, pulse the strobe, await completion
  task automatic send(input logic [7:0] code, f, sc, output logic seen);
    int n;
    n = 0;
    while (busy_i && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    // Still busy after the bound: report no completion
    if (busy_i) begin
      seen = 1'b0;
      return;
    end
    cmd_code_o = code;
    features_o = f;
    sector_count_o = sc;
    cmd_valid_o = 1'b1;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    seen = 1'b0;
    for (n = 0; n < 600 && !seen; n++) begin
      if (done_i) seen = 1'b1;
      else @(negedge clk_i);
    end
  endtask : send
endmodule : fsc_host_model
`default_nettype wire

// *** test/feature_select_command_decoder_test.sv ***
// Self-checking bench for the feature-selection command decoder
`default_nettype none
module feature_select_command_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
  logic       clk_i = 1'b0, rst_n_i = 1'b0, soft_reset_i = 1'b0, dacc = 1'b0;
  logic       cmd_valid, flush_done, busy, done, abort, cyl_load, flush_start, byte_mode;
  logic       sixteen, wc, pio_ok, iordy, udma, apm, stby, ext_pw, pl1, rla, ecc4, por, seen;
  logic [7:0] cmd_code, feat, scnt, cyl_lo, cyl_hi, lvl, cur, rf;
  logic [2:0] pio, dma, e_pio, e_dma;
  logic       e_byte, e_wc, e_rdy, e_udma, e_apm, e_ext, e_pl1, e_rla, e_ecc, e_por, e_ab;
  logic [7:0] e_lvl, e_cur;
  int         errors = 0, comparisons = 0;
  logic [15:0] corners [34] = '{16'h030C, 16'h0301, 16'h0300, 16'h030B, 16'h0302, 16'h030D,
    16'h0322, 16'h0344, 16'h0345, 16'h0320, 16'h0323, 16'h0310, 16'h0380, 16'h0500, 16'h05FF,
    16'h0580, 16'h057F, 16'h0501, 16'h05FE, 16'h0581, 16'h8500, 16'h9A00, 16'h9AFF, 16'h9A14,
    16'hBB00, 16'h6900, 16'h9600, 16'h9700, 16'h0A00, 16'h8A00, 16'h0900, 16'h8900, 16'hAA00,
    16'h1200};
  logic [7:0] codes [20] = '{8'h01, 8'h81, 8'h02, 8'h82, 8'h03, 8'h05, 8'h85, 8'h09, 8'h89,
    8'h0A, 8'h8A, 8'h55, 8'hAA, 8'h66, 8'hCC, 8'h69, 8'h96, 8'h97, 8'h9A, 8'hBB};
  always #4 clk_i = ~clk_i;
  always @(negedge clk_i) dacc = 1'($urandom);
  fsc_decoder i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_code_i(cmd_code), .features_i(feat), .sector_count_i(scnt), .soft_reset_i(soft_reset_i),
    .flush_done_i(flush_done), .data_reg_access_i(dacc), .busy_o(busy), .done_o(done),
    .abort_o(abort), .cyl_low_o(cyl_lo), .cyl_high_o(cyl_hi), .cyl_load_o(cyl_load),
    .flush_start_o(flush_start), .byte_mode_o(byte_mode), .sixteen_bit_io_indicator_o(sixteen),
    .write_cache_o(wc), .pio_mode_valid_o(pio_ok), .pio_mode_o(pio), .iordy_en_o(iordy),
    .dma_is_udma_o(udma), .dma_mode_o(dma), .apm_en_o(apm), .apm_level_o(lvl),
    .apm_standby_ok_o(stby), .ext_power_o(ext_pw), .pl1_en_o(pl1), .look_ahead_o(rla),
    .ecc4_o(ecc4), .por_reload_o(por), .cur_limit_o(cur));
  fsc_host_model i_host (.clk_i(clk_i), .busy_i(busy), .done_i(done),
    .flush_start_i(flush_start), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
    .features_o(feat), .sector_count_o(scnt), .flush_done_o(flush_done));
  //////////////////////////////////////////////////////////////////////////////
  // Power-on settings
  task automatic defaults();
    {e_byte, e_wc, e_rdy, e_udma, e_apm, e_ext, e_pl1, e_rla, e_ecc} = 9'b011000001;
    {e_pio, e_dma, e_lvl, e_cur} = {6'h00, fsc_pkg::APM_DEF, fsc_pkg::CUR_MAX};
  endtask : defaults
  // Expected effect of one subcommand
  task automatic model(input logic [7:0] f, sc);
    e_ab = 1'b0;
    case (f)
      8'h01, 8'h81: e_byte = ~f[7];
      8'h02, 8'h82: e_wc = ~f[7];
      8'h0A, 8'h8A: e_pl1 = ~f[7];
      8'h09, 8'h89: e_ext = ~f[7];
      8'h55, 8'hAA: e_rla = f[7];
      8'h66, 8'hCC: e_por = f[7];
      8'h85: e_apm = 1'b0;
      8'hBB: e_ecc = 1'b1;
      8'h69, 8'h96, 8'h97: e_ab = 1'b0;
      8'h9A: e_cur = sc < fsc_pkg::CUR_MIN ? fsc_pkg::CUR_MIN :
        (sc > fsc_pkg::CUR_MAX ? fsc_pkg::CUR_MAX : sc);
      8'h05: if (sc == 8'h00 || sc == 8'hFF) e_ab = 1'b1; else {e_apm, e_lvl} = {1'b1, sc};
      8'h03: case (sc[7:3])
        5'h00: if (sc[2:1] != 2'h0) e_ab = 1'b1; else {e_pio, e_rdy} = {3'h0, ~sc[0]};
        5'h01: if (sc[2:0] > fsc_pkg::PIO_MAX) e_ab = 1'b1;
          else {e_pio, e_rdy} = {sc[2:0], e_rdy | (sc[2:0] >= 3'h3)};
        5'h04, 5'h08: if (sc[2:0] > (sc[6] ? fsc_pkg::UDMA_MAX : fsc_pkg::MDMA_MAX)) e_ab = 1'b1;
          else {e_udma, e_dma} = {sc[6], sc[2:0]};
        default: e_ab = 1'b1;
      endcase
      default: e_ab = 1'b1;
    endcase
  endtask : model
  // Compare every setting against the expectation; power level only while APM is enabled
  task automatic check_all();
    `CHK(abort, e_ab)
    `CHK({byte_mode, wc, pl1, ext_pw}, {e_byte, e_wc, e_pl1, e_ext})
    `CHK({rla, por, ecc4}, {e_rla, e_por, e_ecc})
    `CHK({pio, iordy, udma, dma}, {e_pio, e_rdy, e_udma, e_dma})
    `CHK({apm, stby}, {e_apm, e_apm && e_lvl < 8'h80})
    if (e_apm) `CHK(lvl, e_lvl)
    `CHK(cur, e_cur)
  endtask : check_all
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // One command with completion bound and full comparison
  task automatic run(input logic [7:0] f, sc);
    i_host.send(fsc_pkg::CMD_SET_FEATURES, f, sc, seen);
    if (!seen) begin
      errors++;
      end_of_test();
    end
    model(f, sc);
    @(negedge clk_i);
    check_all();
    if (f == 8'h9A) `CHK({cyl_lo, cyl_hi}, {fsc_pkg::CUR_MIN, fsc_pkg::CUR_MAX})
  endtask : run
  task automatic soft_rst();
    soft_reset_i = 1'b1;
    @(negedge clk_i);
    soft_reset_i = 1'b0;
    @(negedge clk_i);
    if (e_por) defaults();
    check_all();
  endtask : soft_rst
  // Main sequence
  initial begin
    void'($urandom(32'h24f1));
    e_por = 1'b1;
    e_ab = 1'b0;
    defaults();
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    check_all();
    foreach (corners[i]) run(corners[i][15:8], corners[i][7:0]);
    i_host.send(8'hEC, 8'h01, 8'h00, seen);
    `CHK(seen, 1'b0)
    i_host.slow = 1'b1;
    run(8'h82, 8'h00);
    i_host.slow = 1'b0;
    run(8'h01, 8'h00);
    run(8'hAA, 8'h00);
    soft_rst();
    run(8'h66, 8'h00);
    run(8'h01, 8'h00);
    soft_rst();
    run(8'hCC, 8'h00);
    repeat (300) begin
      rf = ($urandom_range(9) != 0) ? codes[$urandom_range(19)] : 8'($urandom);
      run(rf, 8'($urandom));
    end
    end_of_test();
  end
endmodule : feature_select_command_decoder_test
`default_nettype wire
